// ---- bench/pec_top_asserts.sv ----
module pec_top_asserts #(
   parameter CW = 20
) (
   input wire          i_clk,
   input wire          i_rst_b,
   input wire          i_ctr0_wr,
   input wire [CW-1:0] i_ctr0_wr_data,
   input wire          i_ctr1_wr,
   input wire          i_method_select,
   input wire [1:0]    i_input_select,
   input wire [1:0]    i_counter_irq_enable,
   input wire          i_system_count_enable,
   input wire          i_process_count_enable,
   input wire          i_counter_zero_enable,
   input wire          i_counter_one_enable,
   input wire [1:0]    i_hw_irq_clear,
   input wire          i_privileged_firmware_mode,
   input wire          i_cache_miss,
   input wire [CW-1:0] o_event_counter_zero,
   input wire [CW-1:0] o_event_counter_one,
   input wire [1:0]    o_counter_irq_summary,
   input wire          o_irq_summary
);
   // Read view lags the counter, so steps are judged across two edges
   wire       qual = i_system_count_enable | i_process_count_enable;
   wire       agg1 = ~i_method_select & ~i_ctr1_wr;
   wire       on1  = i_counter_one_enable & qual & agg1;
   wire       cyc1 = on1 & (i_input_select == 2'h0);
   wire       off1 = ~(i_counter_one_enable & qual) & agg1
                     & (i_input_select == 2'h0);
   wire       mis1 = on1 & (i_input_select == 2'h2);
   wire       cyc0 = i_counter_zero_enable & qual & ~i_method_select
                     & ~i_ctr0_wr & i_input_select[0];
   wire [1:0] keep = o_counter_irq_summary & ~i_hw_irq_clear
                     & ~{i_ctr1_wr, i_ctr0_wr};

   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);

   chk_irq_quiet: assert property (
      i_privileged_firmware_mode |=> !o_irq_summary)
      else $error("irq raised in firmware mode");
   chk_irq_or: assert property (
      !i_privileged_firmware_mode |=> o_irq_summary == |o_counter_irq_summary)
      else $error("irq does not follow summary");
   chk_sum_hold: assert property (
      ##1 ((o_counter_irq_summary & $past(keep)) == $past(keep)))
      else $error("summary bit dropped without clear");
   chk_sum_mask: assert property (
      (o_counter_irq_summary & ~$past(o_counter_irq_summary)
       & ~$past(i_counter_irq_enable)) == 2'b00)
      else $error("masked summary bit set");
   chk_cyc_one: assert property (
      cyc1 ##1 cyc1 |=> o_event_counter_one == $past(o_event_counter_one)
                        + CW'(1))
      else $error("counter one cycle step wrong");
   chk_cyc_zero: assert property (
      cyc0 ##1 cyc0 |=> o_event_counter_zero == $past(o_event_counter_zero)
                        + CW'(1))
      else $error("counter zero cycle step wrong");
   chk_hold_off: assert property (
      off1 ##1 off1 |=> $stable(o_event_counter_one))
      else $error("disabled counter moved");
   chk_miss_now: assert property (
      mis1 ##1 mis1 |=> o_event_counter_one == $past(o_event_counter_one)
                        + CW'($past(i_cache_miss)))
      else $error("cache miss count wrong");
   chk_wr_load: assert property (
      i_ctr0_wr ##1 (~i_ctr0_wr & ~i_method_select & i_input_select[0])
      |=> o_event_counter_zero == $past(i_ctr0_wr_data, 2) + CW'(1))
      else $error("written value not read back");
   chk_ovf_set: assert property (
      cyc1 ##1 (cyc1 && o_event_counter_one == {CW{1'b1}}
                && i_counter_irq_enable[1]) |=> o_counter_irq_summary[1])
      else $error("overflow did not set summary");
endmodule

bind pec_top pec_top_asserts #(.CW(CW)) u_chk (.*);

// ---- bench/pec_top_tb_top.sv ----
module pec_top_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        i_clk = 1'b0, i_rst_b = 1'b0;
   logic        i_privileged_firmware_mode = 1'b1;
   logic        i_ctr0_wr = 1'b0, i_ctr1_wr = 1'b0, i_method_select = 1'b0;
   logic        i_system_count_enable = 1'b0, i_process_count_enable = 1'b0;
   logic        i_counter_zero_enable = 1'b0, i_counter_one_enable = 1'b0;
   logic        i_cache_miss = 1'b0, i_replay_trap = 1'b0, o_irq_summary;
   logic [1:0]  i_input_select = '0, i_counter_irq_enable = '0;
   logic [1:0]  i_hw_irq_clear = '0, o_counter_irq_summary;
   logic [10:0] i_retire_valid = '0, i_retire_squash = '0;
   logic [3:0]  i_fetch_valid = '0, i_fetch_squash = '0, i_fetch_nop = '0;
   logic [3:0]  i_fetch_cond_move = '0;
   logic [19:0] i_ctr0_wr_data = '0, i_ctr1_wr_data = '0, e0 = '0, e1 = '0;
   logic [19:0] o_event_counter_zero, o_event_counter_one;
   logic [23:0] exp_q[$];
   logic [23:0] nt;
   logic [31:0] seed = 32'ha6e8_52b6;
   int          fails = 0;
   int          num_checks = 0;

   pec_top u_dut (.*);

   always #2.5 i_clk = ~i_clk;

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic end_sim;
      if (fails == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic cmp_ctr(input logic [19:0] got, input logic [19:0] want);
      num_checks++;
      if (got !== want) begin
         fails++;
         $display("[FAIL] %0t counter %h expected %h", $time, got, want);
      end
   endtask

   task automatic cmp_bit(input logic [1:0] got, input logic [1:0] want);
      num_checks++;
      if (got !== want) begin
         fails++;
         $display("[FAIL] %0t flags %b expected %b", $time, got, want);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Notes are taken at the falling edge and judged after the next rise
   always @(posedge i_clk) begin
      #1;
      while (exp_q.size() > 0) begin
         nt = exp_q.pop_front();
         case (nt[23:20])
            4'h0: cmp_ctr(o_event_counter_zero, nt[19:0]);
            4'h1: cmp_ctr(o_event_counter_one, nt[19:0]);
            4'h2: cmp_bit(o_counter_irq_summary, nt[1:0]);
            default: cmp_bit({1'b0, o_irq_summary}, nt[1:0]);
         endcase
      end
   end

   // Idle reads carry the ungated cycle increment in cycle modes
   task automatic chk(input logic [1:0] s, input logic q);
      exp_q.push_back({4'h0, e0 + (~i_method_select & i_input_select[0])});
      exp_q.push_back({4'h1, e1 + (i_method_select | (i_input_select == 0))});
      exp_q.push_back({4'h2, 18'h0, s});
      exp_q.push_back({4'h3, 19'h0, q});
      @(negedge i_clk);
   endtask

   task automatic wr(input logic [19:0] a, input logic [19:0] b);
      {i_ctr0_wr, i_ctr1_wr} = 2'b11;
      i_ctr0_wr_data = a;
      i_ctr1_wr_data = b;
      e0 = a;
      e1 = b;
      @(negedge i_clk);
      {i_ctr0_wr, i_ctr1_wr} = 2'b00;
      // Let an edge pass so a following write raises a fresh strobe
      @(negedge i_clk);
   endtask

   // Twelve quiet cycles let delayed events and the carry drain
   task automatic burst(input int n, input logic [1:0] m, input int ev);
      logic [3:0] a, b, pick;
      bit         g;
      {i_system_count_enable, i_process_count_enable} = m;
      {i_counter_zero_enable, i_counter_one_enable} = 2'b11;
      for (int i = 0; i < n + 12; i++) begin
         seed = lfsr(seed);
         g = (ev != 0) && (i < n);
         i_retire_valid = g ? (ev == 2 ? 11'h7ff : seed[10:0]) : 11'h0;
         i_retire_squash = (g && ev == 1) ? seed[21:11] : 11'h0;
         i_fetch_valid = g ? seed[25:22] : 4'h0;
         i_fetch_squash = seed[29:26];
         i_fetch_nop = seed[31:28];
         i_fetch_cond_move = g ? seed[3:0] & seed[25:22] : 4'h0;
         i_cache_miss = g & seed[12];
         i_replay_trap = g & seed[13];
         pick = {i_replay_trap, i_cache_miss, 2'b01};
         a = i_input_select[0] ? 4'h1
             : 4'($countones(i_retire_valid & ~i_retire_squash));
         b = pick[i_input_select];
         if (i_method_select) begin
            // Squashed moves count neither half unless also marked no-op
            pick = i_fetch_valid & (~i_fetch_squash | i_fetch_nop);
            a = 4'($countones(pick) + $countones(pick & i_fetch_cond_move));
            b = 4'h1;
         end
         if (m != 2'b00) begin
            e0 = e0 + a;
            e1 = e1 + b;
         end
         @(negedge i_clk);
      end
      {i_counter_zero_enable, i_counter_one_enable} = 2'b00;
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (16) @(posedge i_clk);
      @(negedge i_clk);
      i_rst_b = 1'b1;
      chk(2'b00, 1'b0);
      wr(20'h0_0000, 20'h0_0000);
      wr(20'h0_0000, 20'h0_0000);
      i_privileged_firmware_mode = 1'b0;
      for (int s = 0; s < 4; s++) begin
         i_input_select = s[1:0];
         burst(8, 2'b10, 1);
         chk(2'b00, 1'b0);
      end
      i_input_select = 2'h0;
      for (int m = 0; m < 4; m++) begin
         burst(6, m[1:0], 0);
         chk(2'b00, 1'b0);
      end
      burst(8, 2'b01, 2);
      chk(2'b00, 1'b0);
      i_method_select = 1'b1;
      wr(20'h0_0000, 20'h0_0000);
      burst(8, 2'b01, 1);
      chk(2'b00, 1'b0);
      i_method_select = 1'b0;
      i_counter_irq_enable = 2'b10;
      wr(20'hf_fff0, 20'hf_fffc);
      burst(5, 2'b10, 2);
      chk(2'b10, 1'b1);
      i_input_select = 2'h1;
      i_counter_irq_enable = 2'b01;
      wr(20'hf_fff0, 20'h0_0005);
      burst(5, 2'b10, 0);
      chk(2'b01, 1'b1);
      i_privileged_firmware_mode = 1'b1;
      @(negedge i_clk);
      chk(2'b01, 1'b0);
      i_hw_irq_clear = 2'b01;
      @(negedge i_clk);
      i_hw_irq_clear = 2'b00;
      chk(2'b00, 1'b0);
      i_privileged_firmware_mode = 1'b0;
      wr(20'hf_fff0, 20'h0_0000);
      burst(3, 2'b10, 0);
      i_privileged_firmware_mode = 1'b1;
      chk(2'b00, 1'b0);
      // Counter sits at threshold and disabled while firmware rewrites it
      wr(20'h0_0000, 20'h0_0000);
      chk(2'b00, 1'b0);
      i_privileged_firmware_mode = 1'b0;
      @(negedge i_clk);
      chk(2'b01, 1'b1);
      end_sim();
   end

   initial begin
      repeat (5000) @(posedge i_clk);
      fails++;
      end_sim();
   end
endmodule

// ---- logic/pec_counter.v ----
`include "pec_regs.vh"

module pec_counter #(
   parameter W = `PEC_CTR_W
) (
   input  wire                  i_clk,
   input  wire                  i_rst_b,
   input  wire                  i_wr,
   input  wire [W-1:0]          i_wr_data,
   input  wire                  i_en,
   input  wire [`PEC_INC_W-1:0] i_inc,
   input  wire                  i_clr,
   input  wire                  i_priv_exit,
   output wire [W-1:0]          o_value,
   output wire                  o_ovf,
   output wire                  o_wr_ovf
);

   reg  [W-1:0] count_q;
   reg          pend_q;
   wire [W:0]   sum;
   wire         at_thresh;

   assign sum       = {1'b0, count_q} + {{(W-3){1'b0}}, i_inc};
   assign at_thresh = (count_q == {W{1'b1}});

   ////////////////////////////////////////////////////////////////////////
   // Count; a write takes priority over counting in the same cycle
   always @(posedge i_clk) begin
      if (!i_rst_b) begin
         count_q <= {W{1'b0}};
      end else if (i_wr) begin
         count_q <= i_wr_data;
      end else if (i_en) begin
         count_q <= sum[W-1:0];
      end
   end

   assign o_ovf = i_en & ~i_wr & sum[W];

   ////////////////////////////////////////////////////////////////////////
   // Write-at-threshold latch; a second write clears it, hence the
   // double write at init
   always @(posedge i_clk) begin
      if (!i_rst_b) begin
         pend_q <= 1'b0;
      end else if (i_wr) begin
         pend_q <= at_thresh;
      end else if (i_clr | i_priv_exit) begin
         pend_q <= 1'b0;
      end
   end

   assign o_wr_ovf = pend_q & i_priv_exit;
   assign o_value  = count_q;

endmodule

// ---- logic/pec_delay.v ----
module pec_delay #(
   parameter W = 8,
   parameter N = 3
) (
   input  wire         i_clk,
   input  wire         i_rst_b,
   input  wire [W-1:0] i_data,
   output wire [W-1:0] o_data
);

   // Shift line; output taken from the last stage flops
   reg [W*N-1:0] pipe_q;

   always @(posedge i_clk) begin
      if (!i_rst_b) begin
         pipe_q <= {(W*N){1'b0}};
      end else begin
         pipe_q <= {pipe_q[W*(N-1)-1:0], i_data};
      end
   end

   assign o_data = pipe_q[W*N-1 -: W];

endmodule

// ---- logic/pec_regs.vh ----
`ifndef PEC_REGS_VH
`define PEC_REGS_VH

////////////////////////////////////////////////////////////////////////////
// Counter geometry
`define PEC_CTR_W        20
`define PEC_CTR_MAX      20'hF_FFFF
`define PEC_INC_W        4

////////////////////////////////////////////////////////////////////////////
// Retire and fetch lanes
`define PEC_RET_LANES    11
`define PEC_RET_MAX_INC  4'h8
`define PEC_BACKLOG_W    6
`define PEC_FETCH_LANES  4

////////////////////////////////////////////////////////////////////////////
// Cycles by which the cache miss input leads the other events
`define PEC_EARLY_CYC    3

////////////////////////////////////////////////////////////////////////////
// Method select values
`define PEC_METHOD_AGG   1'b0
`define PEC_METHOD_SMP   1'b1

////////////////////////////////////////////////////////////////////////////
// Input select values in aggregate mode
`define PEC_SEL_RET_CYC  2'h0
`define PEC_SEL_CYC_UND  2'h1
`define PEC_SEL_RET_MISS 2'h2
`define PEC_SEL_CYC_RPL  2'h3

////////////////////////////////////////////////////////////////////////////
// Summary bit positions
`define PEC_SUM_CTR0     0
`define PEC_SUM_CTR1     1

////////////////////////////////////////////////////////////////////////////
// Fixed increments
`define PEC_INC_ONE      4'h1
`define PEC_INC_ZERO     4'h0

`endif

// ---- logic/pec_top.v ----
`include "pec_regs.vh"

module pec_top #(
   parameter CW = `PEC_CTR_W,
   parameter RL = `PEC_RET_LANES,
   parameter FL = `PEC_FETCH_LANES,
   parameter BW = `PEC_BACKLOG_W
) (
   input  wire          i_clk,
   input  wire          i_rst_b,
   // Counter writes from privileged firmware
   input  wire          i_ctr0_wr,
   input  wire [CW-1:0] i_ctr0_wr_data,
   input  wire          i_ctr1_wr,
   input  wire [CW-1:0] i_ctr1_wr_data,
   // Control bits
   input  wire          i_method_select,
   input  wire [1:0]    i_input_select,
   input  wire [1:0]    i_counter_irq_enable,
   input  wire          i_system_count_enable,
   input  wire          i_process_count_enable,
   input  wire          i_counter_zero_enable,
   input  wire          i_counter_one_enable,
   input  wire [1:0]    i_hw_irq_clear,
   input  wire          i_privileged_firmware_mode,
   // Core events
   input  wire [RL-1:0] i_retire_valid,
   input  wire [RL-1:0] i_retire_squash,
   input  wire [FL-1:0] i_fetch_valid,
   input  wire [FL-1:0] i_fetch_squash,
   input  wire [FL-1:0] i_fetch_nop,
   input  wire [FL-1:0] i_fetch_cond_move,
   input  wire          i_cache_miss,
   input  wire          i_replay_trap,
   // Status
   output wire [CW-1:0] o_event_counter_zero,
   output wire [CW-1:0] o_event_counter_one,
   output wire [1:0]    o_counter_irq_summary,
   output wire          o_irq_summary
);

   ////////////////////////////////////////////////////////////////////////
   // Helpers

   function [3:0] pop_ret;
      input [RL-1:0] v;
      integer k;
      begin
         pop_ret = 4'h0;
         for (k = 0; k < RL; k = k + 1) begin
            pop_ret = pop_ret + {3'h0, v[k]};
         end
      end
   endfunction

   function [3:0] pop_fetch;
      input [FL-1:0] v;
      integer k;
      begin
         pop_fetch = 4'h0;
         for (k = 0; k < FL; k = k + 1) begin
            pop_fetch = pop_fetch + {3'h0, v[k]};
         end
      end
   endfunction

   function [CW-1:0] add_inc;
      input [CW-1:0] a;
      input [3:0]    b;
      begin
         add_inc = a + {{(CW-4){1'b0}}, b};
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Early-event alignment
   // Everything but the cache miss is delayed, so the miss input is
   // effectively seen three cycles ahead of the rest

   localparam DW = 4 + 1 + 4 * FL;

   wire [3:0]    ret_now;
   wire [DW-1:0] dly_in;
   wire [DW-1:0] dly_out;
   wire [3:0]    ret_dly;
   wire          rpl_dly;
   wire [FL-1:0] fv_dly;
   wire [FL-1:0] fs_dly;
   wire [FL-1:0] fn_dly;
   wire [FL-1:0] fc_dly;

   assign ret_now = pop_ret(i_retire_valid & ~i_retire_squash);

   assign dly_in = {ret_now, i_replay_trap, i_fetch_valid,
                    i_fetch_squash, i_fetch_nop, i_fetch_cond_move};

   pec_delay #(
      .W (DW),
      .N (`PEC_EARLY_CYC)
   ) u_align (
      .i_clk   (i_clk),
      .i_rst_b (i_rst_b),
      .i_data  (dly_in),
      .o_data  (dly_out)
   );

   assign ret_dly = dly_out[DW-1 -: 4];
   assign rpl_dly = dly_out[4*FL];
   assign fv_dly  = dly_out[4*FL-1 -: FL];
   assign fs_dly  = dly_out[3*FL-1 -: FL];
   assign fn_dly  = dly_out[2*FL-1 -: FL];
   assign fc_dly  = dly_out[FL-1:0];

   ////////////////////////////////////////////////////////////////////////
   // Enables and mode decode

   wire qual;
   wire en0;
   wire en1;
   wire agg;
   wire c0_ret;

   assign qual = i_system_count_enable | i_process_count_enable;
   assign en0  = i_counter_zero_enable & qual;
   assign en1  = i_counter_one_enable & qual;
   assign agg  = (i_method_select == `PEC_METHOD_AGG);
   assign c0_ret = agg & ~i_input_select[0];

   ////////////////////////////////////////////////////////////////////////
   // Retire backlog
   // Up to eight retires go in per cycle; the rest wait here. The backlog
   // is held, not dropped, while counting is off, so it shows as the
   // in-flight part of a read

   reg  [BW-1:0] backlog_q;
   reg  [BW-1:0] backlog_d;
   reg  [3:0]    ret_add;
   wire [BW-1:0] ret_total;

   assign ret_total = backlog_q + {{(BW-4){1'b0}}, ret_dly};

   always @* begin
      if (ret_total > {{(BW-4){1'b0}}, `PEC_RET_MAX_INC}) begin
         ret_add = `PEC_RET_MAX_INC;
      end else begin
         ret_add = ret_total[3:0];
      end
      backlog_d = backlog_q;
      if (en0 & c0_ret & ~i_ctr0_wr) begin
         backlog_d = ret_total - {{(BW-4){1'b0}}, ret_add};
      end
   end

   // Limitation: a sustained burst above eight per cycle saturates nothing;
   // the core cannot keep that up, so the backlog stays small
   always @(posedge i_clk) begin
      if (!i_rst_b) begin
         backlog_q <= {BW{1'b0}};
      end else begin
         backlog_q <= backlog_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Fetched-instruction count for sampling mode
   // A squashed no-op still counts; a conditional move counts its first
   // half now and its second half in the next cycle

   wire [FL-1:0] f_cnt;
   wire [3:0]    f_now;
   wire [3:0]    f_inc;
   reg  [3:0]    conditional_move_q;

   assign f_cnt = fv_dly & (~fs_dly | fn_dly);
   assign f_now = pop_fetch(f_cnt);
   assign f_inc = f_now + conditional_move_q;

   always @(posedge i_clk) begin
      if (!i_rst_b) begin
         conditional_move_q <= 4'h0;
      end else begin
         conditional_move_q <= pop_fetch(f_cnt & fc_dly);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Event selection

   reg [3:0] inc0;
   reg [3:0] inc1;

   always @* begin
      inc0 = `PEC_INC_ZERO;
      inc1 = `PEC_INC_ZERO;
      if (!agg) begin
         inc0 = f_inc;
         inc1 = `PEC_INC_ONE;
      end else begin
         case (i_input_select)
            `PEC_SEL_RET_CYC: begin
               inc0 = ret_add;
               inc1 = `PEC_INC_ONE;
            end
            `PEC_SEL_CYC_UND: begin
               inc0 = `PEC_INC_ONE;
               inc1 = `PEC_INC_ZERO;
            end
            `PEC_SEL_RET_MISS: begin
               inc0 = ret_add;
               inc1 = {3'h0, i_cache_miss};
            end
            `PEC_SEL_CYC_RPL: begin
               inc0 = `PEC_INC_ONE;
               inc1 = {3'h0, rpl_dly};
            end
            default: begin
               inc0 = `PEC_INC_ZERO;
               inc1 = `PEC_INC_ZERO;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Leaving privileged firmware mode

   reg  priv_q;
   wire priv_exit;

   always @(posedge i_clk) begin
      if (!i_rst_b) begin
         priv_q <= 1'b1;
      end else begin
         priv_q <= i_privileged_firmware_mode;
      end
   end

   assign priv_exit = priv_q & ~i_privileged_firmware_mode;

   ////////////////////////////////////////////////////////////////////////
   // Counters

   wire [CW-1:0] val0;
   wire [CW-1:0] val1;
   wire          ovf0;
   wire          ovf1;
   wire          wovf0;
   wire          wovf1;

   pec_counter #(
      .W (CW)
   ) u_ctr0 (
      .i_clk       (i_clk),
      .i_rst_b     (i_rst_b),
      .i_wr        (i_ctr0_wr),
      .i_wr_data   (i_ctr0_wr_data),
      .i_en        (en0),
      .i_inc       (inc0),
      .i_clr       (i_hw_irq_clear[`PEC_SUM_CTR0]),
      .i_priv_exit (priv_exit),
      .o_value     (val0),
      .o_ovf       (ovf0),
      .o_wr_ovf    (wovf0)
   );

   pec_counter #(
      .W (CW)
   ) u_ctr1 (
      .i_clk       (i_clk),
      .i_rst_b     (i_rst_b),
      .i_wr        (i_ctr1_wr),
      .i_wr_data   (i_ctr1_wr_data),
      .i_en        (en1),
      .i_inc       (inc1),
      .i_clr       (i_hw_irq_clear[`PEC_SUM_CTR1]),
      .i_priv_exit (priv_exit),
      .o_value     (val1),
      .o_ovf       (ovf1),
      .o_wr_ovf    (wovf1)
   );

   ////////////////////////////////////////////////////////////////////////
   // Summary bits; a set in the same cycle as a clear wins

   reg  [1:0] summ_q;
   wire [1:0] summ_set;
   wire [1:0] summ_clr;
   wire [1:0] summ_d;

   assign summ_set = i_counter_irq_enable &
                     ({ovf1, ovf0} | {wovf1, wovf0});
   assign summ_clr = i_hw_irq_clear | {i_ctr1_wr, i_ctr0_wr};
   assign summ_d   = (summ_q & ~summ_clr) | summ_set;

   always @(posedge i_clk) begin
      if (!i_rst_b) begin
         summ_q <= 2'h0;
      end else begin
         summ_q <= summ_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupt delivery, held back in firmware mode

   reg irq_q;

   always @(posedge i_clk) begin
      if (!i_rst_b) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= (|summ_d) & ~i_privileged_firmware_mode;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read view
   // The read adds this cycle's increment even with counting off; the
   // cheaper path was kept over an exact disabled read

   reg [CW-1:0] rd0_q;
   reg [CW-1:0] rd1_q;

   always @(posedge i_clk) begin
      if (!i_rst_b) begin
         rd0_q <= {CW{1'b0}};
         rd1_q <= {CW{1'b0}};
      end else begin
         rd0_q <= add_inc(val0, inc0);
         rd1_q <= add_inc(val1, inc1);
      end
   end

   assign o_event_counter_zero  = rd0_q;
   assign o_event_counter_one   = rd1_q;
   assign o_counter_irq_summary = summ_q;
   assign o_irq_summary         = irq_q;

endmodule
